// file: rtl/descriptor_store_map.svh
// Field values, byte offsets and bus map of the device descriptor store
`ifndef DESCRIPTOR_STORE_MAP_SVH
`define DESCRIPTOR_STORE_MAP_SVH

// Device descriptor field values
`define DD_SIZE            8'h40
`define DD_TYPE_ID         8'h00
`define DD_DEVICE_TYPE     8'h00
`define DD_CLASS           8'h00
`define DD_SUBCLASS        8'h00
`define DD_PROTOCOL        8'h00
`define DD_LU_COUNT        8'h01
`define DD_WLU_COUNT       8'h04
`define DD_BOOT_EN         8'h00
`define DD_DESC_ACC_EN     8'h00
`define DD_INIT_PWR_MODE   8'h01
`define DD_HIPRI_LUN       8'h7F
`define DD_SEC_REMOVAL     8'h03
`define DD_SECURITY_LU     8'h01
`define DD_BG_STOP_LAT     8'h0F
`define DD_INIT_CUR_LVL    8'h0F
`define DD_SPEC_VERSION    16'h0210
`define DD_MAKER_IDX       8'h00
`define DD_PRODUCT_IDX     8'h01
`define DD_SERIAL_IDX      8'h03
`define DD_OEM_IDX         8'h04
`define DD_FIRST_UNIT_OFS  8'h10
`define DD_UNIT_CFG_LEN    8'h10
`define DD_XFER_LIMIT      8'h02
`define DD_TIME_POLICY     16'h0000
`define DD_FEATURES        8'h01
`define DD_FWU_TIMEOUT     8'h07
`define DD_QUEUE_DEPTH     8'h20
`define DD_DEV_VERSION     16'h0000
`define DD_SECURE_AREAS    8'h20
`define DD_PRELOAD_TIMEOUT 8'h11
`define DD_REVISION_IDX    8'h02

// Byte offsets of fields that take a parameter value, and of the last field
`define OFS_MFG_DATE       8'h12
`define OFS_MAKER_ID       8'h18
`define OFS_PRELOAD_SIZE   8'h27
`define OFS_LAST_FIELD     8'h2C

// String descriptor layouts
`define STR_TYPE           8'h05
`define STR_MAKER_LEN      8'h12
`define STR_PRODUCT_LEN    8'h22
`define STR_SERIAL_LEN     8'h0C
`define STR_OEM_LEN        8'h32
`define STR_REV_LEN        8'h04

// Unit descriptor header
`define UNIT_SIZE          8'h23
`define UNIT_TYPE_ID       8'h02

// Register bus map (word index = addr)
`define REG_DESC_SEL       4'h0
`define REG_BYTE_OFS       4'h1
`define REG_READ_DATA      4'h2
`define REG_AVAIL_LEN      4'h3
`define REG_STATUS         4'h4

// Descriptor selectors
`define SEL_DEVICE         3'h0
`define SEL_STRING_INFO    3'h1
`define SEL_UNIT           3'h2
`endif

// file: rtl/descriptor_store_pkg.sv
// Types shared by the descriptor store
package descriptor_store_pkg;
  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01
  } access_state_t;

  typedef struct packed {
    logic [2:0]    sel;
    logic [7:0]    ofs;
    logic [7:0]    idx;
    logic [31:0]   rdata;
    logic          overrun;
    access_state_t state;
  } store_state_t;
endpackage

// file: rtl/ufs_device_descriptor_store.sv
// Read-only descriptor store reached by byte offset over a plain register port
// Notes on behaviour
// (RL1) Device descriptor reports size 64 and type id zero in first two bytes.
// (RL2) Device class byte is zero, mass storage.
// (RL3) Subclass byte is zero, embedded bootable.
// (RL4) Command protocol byte is zero, SCSI.
// (RL5) Four well-known units and one ordinary logical unit, one byte each.
// (RL6) Background stop latency byte reads fifteen.
// (RL7) Initial current level byte reads fifteen.
// (RL8) Maker string at index zero, length 0x12, type 5, Unicode.
// (RL9) Product string at index one, length 0x22, type 5, Unicode.
// (RL10) Serial string at index three, length 0xC: CRC, date, random, reserved.
// (RL11) OEM string at index four, length 0x32, type 5, blank.
// (RL12) Revision string at index two, length 4: major then minor version.
// (RL13) Two-byte maker identity code is a descriptor field set by module parameter.
// (RL14) First unit offset 16 and unit config length 16, one byte each.
// (RL15) At most two outstanding ready-to-transfer requests, advertised in one byte.
// (RL16) Time update policy reads zero in a two-byte field.
// (RL17) Feature byte 0x01: firmware update and reflow preloading supported.
// (RL18) Firmware update timeout byte reads seven.
// (RL19) Thirty-two secure protect areas and command queue depth thirty-two.
// (RL20) Preload max size is four bytes, capacity dependent; preload timeout 0x11.
// (RL21) Unit descriptors report size 0x23 and type id 0x02.
// (RL22) Bytes in field order, multi-byte big-endian; reads stop at declared length.
`timescale 1ns/1ps
`default_nettype none
`include "descriptor_store_map.svh"

module ufs_device_descriptor_store #(
  parameter logic [15:0] MAKER_IDENTITY_CODE = 16'h00A5,       // Arbitrary value
  parameter logic [31:0] PRELOAD_MAX_SIZE    = 32'h0000_0000,
  parameter logic [15:0] MFG_DATE            = 16'h0000
) (
  input  wire logic                           core_clk,
  input  wire logic                           rst_n,
  input  wire descriptor_store_pkg::bus_req_t bus_req,
  output logic [31:0]                         rdata
);

  descriptor_store_pkg::store_state_t state_ff;
  descriptor_store_pkg::store_state_t nxt_state;

  // Device descriptor byte at a given offset; zero past the last field
  function automatic logic [7:0] device_byte(input logic [7:0] o);
    logic [7:0] b;
    b = 8'h00;
    unique case (o)
      8'h00: b = `DD_SIZE;                               // see RL1
      8'h01: b = `DD_TYPE_ID;                            // see RL1
      8'h02: b = `DD_DEVICE_TYPE;
      8'h03: b = `DD_CLASS;                              // see RL2
      8'h04: b = `DD_SUBCLASS;                           // see RL3
      8'h05: b = `DD_PROTOCOL;                           // see RL4
      8'h06: b = `DD_LU_COUNT;                           // see RL5
      8'h07: b = `DD_WLU_COUNT;                          // see RL5
      8'h08: b = `DD_BOOT_EN;
      8'h09: b = `DD_DESC_ACC_EN;
      8'h0A: b = `DD_INIT_PWR_MODE;
      8'h0B: b = `DD_HIPRI_LUN;
      8'h0C: b = `DD_SEC_REMOVAL;
      8'h0D: b = `DD_SECURITY_LU;
      8'h0E: b = `DD_BG_STOP_LAT;                        // see RL6
      8'h0F: b = `DD_INIT_CUR_LVL;                       // see RL7
      8'h10: b = 8'(`DD_SPEC_VERSION >> 8);              // see RL22
      8'h11: b = 8'(`DD_SPEC_VERSION);
      `OFS_MFG_DATE: b = MFG_DATE[15:8];
      8'h13: b = MFG_DATE[7:0];
      8'h14: b = `DD_MAKER_IDX;                          // see RL8
      8'h15: b = `DD_PRODUCT_IDX;                        // see RL9
      8'h16: b = `DD_SERIAL_IDX;                         // see RL10
      8'h17: b = `DD_OEM_IDX;                            // see RL11
      `OFS_MAKER_ID: b = MAKER_IDENTITY_CODE[15:8];      // see RL13
      8'h19: b = MAKER_IDENTITY_CODE[7:0];               // see RL13
      8'h1A: b = `DD_FIRST_UNIT_OFS;                     // see RL14
      8'h1B: b = `DD_UNIT_CFG_LEN;                       // see RL14
      8'h1C: b = `DD_XFER_LIMIT;                         // see RL15
      8'h1D: b = 8'(`DD_TIME_POLICY >> 8);               // see RL16
      8'h1E: b = 8'(`DD_TIME_POLICY);                    // see RL16
      8'h1F: b = `DD_FEATURES;                           // see RL17
      8'h20: b = `DD_FWU_TIMEOUT;                        // see RL18
      8'h21: b = `DD_QUEUE_DEPTH;                        // see RL19
      8'h22: b = 8'(`DD_DEV_VERSION >> 8);
      8'h23: b = 8'(`DD_DEV_VERSION);
      8'h24: b = `DD_SECURE_AREAS;                       // see RL19
      `OFS_PRELOAD_SIZE: b = PRELOAD_MAX_SIZE[31:24];    // see RL20
      8'h28: b = PRELOAD_MAX_SIZE[23:16];
      8'h29: b = PRELOAD_MAX_SIZE[15:8];
      8'h2A: b = PRELOAD_MAX_SIZE[7:0];
      8'h2B: b = `DD_PRELOAD_TIMEOUT;                    // see RL20
      `OFS_LAST_FIELD: b = `DD_REVISION_IDX;             // see RL12
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // String layout by index: {type, length}; unknown index reads zero
  function automatic logic [15:0] string_info(input logic [7:0] i);
    logic [15:0] r;
    r = 16'h0000;
    unique case (i)
      `DD_MAKER_IDX:    r = {`STR_TYPE, `STR_MAKER_LEN};     // see RL8
      `DD_PRODUCT_IDX:  r = {`STR_TYPE, `STR_PRODUCT_LEN};   // see RL9
      `DD_REVISION_IDX: r = {`STR_TYPE, `STR_REV_LEN};       // see RL12
      `DD_SERIAL_IDX:   r = {`STR_TYPE, `STR_SERIAL_LEN};    // see RL10
      `DD_OEM_IDX:      r = {`STR_TYPE, `STR_OEM_LEN};       // see RL11
      default:          r = 16'h0000;
    endcase
    return r;
  endfunction

  // Declared length of the selected descriptor
  function automatic logic [7:0] avail_len(input logic [2:0] s, input logic [7:0] i);
    logic [7:0] l;
    l = 8'h00;
    unique case (s)
      `SEL_DEVICE:      l = `DD_SIZE;
      `SEL_STRING_INFO: l = 8'(string_info(i));
      `SEL_UNIT:        l = `UNIT_SIZE;
      default:          l = 8'h00;
    endcase
    return l;
  endfunction

  logic [7:0] cur_len;
  logic [7:0] cur_byte;

  always_comb begin
    cur_len  = avail_len(state_ff.sel, state_ff.idx);
    cur_byte = 8'h00;
    unique case (state_ff.sel)
      `SEL_DEVICE: cur_byte = device_byte(state_ff.ofs);
      `SEL_UNIT: begin
        if (state_ff.ofs == 8'h00) begin
          cur_byte = `UNIT_SIZE;                         // see RL21
        end else if (state_ff.ofs == 8'h01) begin
          cur_byte = `UNIT_TYPE_ID;                      // see RL21
        end else if (state_ff.ofs == 8'h02) begin
          cur_byte = state_ff.idx;
        end
      end
      default: cur_byte = 8'h00;
    endcase
  end

  always_comb begin
    nxt_state       = state_ff;
    nxt_state.state = descriptor_store_pkg::ST_IDLE;
    nxt_state.rdata = 32'h0000_0000;
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        `REG_DESC_SEL: begin
          nxt_state.sel     = bus_req.wdata[2:0];
          nxt_state.idx     = bus_req.wdata[15:8];
          nxt_state.ofs     = 8'h00;
          nxt_state.overrun = 1'b0;
        end
        `REG_BYTE_OFS: begin
          nxt_state.ofs     = bus_req.wdata[7:0];
          nxt_state.overrun = 1'b0;
        end
        default: nxt_state.sel = state_ff.sel;
      endcase
    end else if (bus_req.rd) begin
      nxt_state.state = descriptor_store_pkg::ST_READ;
      unique case (bus_req.addr)
        `REG_DESC_SEL:  nxt_state.rdata = {16'h0000, state_ff.idx, 5'h00, state_ff.sel};
        `REG_BYTE_OFS:  nxt_state.rdata = {24'h000000, state_ff.ofs};
        `REG_READ_DATA: begin
          // Past the declared length the window returns zero and flags overrun
          if (state_ff.ofs < cur_len) begin                     // see RL22
            nxt_state.rdata = {24'h000000, cur_byte};
            nxt_state.ofs   = state_ff.ofs + 8'h01;
          end else begin
            nxt_state.overrun = 1'b1;                           // see RL22
          end
        end
        `REG_AVAIL_LEN: begin
          if (state_ff.sel == `SEL_STRING_INFO) begin
            nxt_state.rdata = {16'h0000, string_info(state_ff.idx)};
          end else begin
            nxt_state.rdata = {24'h000000, cur_len};
          end
        end
        `REG_STATUS:    nxt_state.rdata = {31'h0000_0000, state_ff.overrun};
        default:        nxt_state.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign rdata = state_ff.rdata;

endmodule
`default_nettype wire

// file: tb/descriptor_store_props.sv
// Checker for the descriptor store register port
`timescale 1ns/1ps
`default_nettype none
module descriptor_store_props (
  input wire logic                           core_clk,
  input wire logic                           rst_n,
  input wire descriptor_store_pkg::bus_req_t bus_req,
  input wire logic [31:0]                    rdata
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [2:0] c_sel;
  logic [7:0] c_idx;
  logic [7:0] c_ofs;
  logic       rd_data;
  assign rd_data = bus_req.rd && bus_req.addr == 4'h2;
  // Shadow of selector, index and offset; device, unit and maker string reads are judged by it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      c_sel <= 3'h0;
      c_idx <= 8'h00;
      c_ofs <= 8'h00;
    end else if (bus_req.wr && bus_req.addr == 4'h0) begin
      c_sel <= bus_req.wdata[2:0];
      c_idx <= bus_req.wdata[15:8];
      c_ofs <= 8'h00;
    end else if (bus_req.wr && bus_req.addr == 4'h1) begin
      c_ofs <= bus_req.wdata[7:0];
    end else if (rd_data && c_ofs < 8'h40) begin
      c_ofs <= c_ofs + 8'h01;
    end
  end
  AST_RDATA_IDLE: assert property (!bus_req.rd |=> rdata == 32'h0)
    else $error("read data not zero outside answer cycle");
  AST_BYTE_ONLY: assert property (rd_data |=> rdata[31:8] == 24'h0)
    else $error("data read wider than one byte");
  AST_UNMAPPED: assert property (bus_req.rd && bus_req.addr > 4'h4 |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  AST_DEV_SIZE: assert property (rd_data && c_sel == 3'h0 && c_ofs == 8'h00 |=> rdata == 32'h40)
    else $error("device size byte wrong");
  AST_DEV_LEN: assert property (bus_req.rd && bus_req.addr == 4'h3 && c_sel == 3'h0
    |=> rdata == 32'h40)
    else $error("device length wrong");
  AST_UNIT_TYPE: assert property (rd_data && c_sel == 3'h2 && c_ofs == 8'h01 |=> rdata == 32'h02)
    else $error("unit type byte wrong");
  AST_UNIT_LEN: assert property (bus_req.rd && bus_req.addr == 4'h3 && c_sel == 3'h2
    |=> rdata == 32'h23)
    else $error("unit length wrong");
  AST_OVERRUN: assert property (rd_data && c_sel == 3'h0 && c_ofs >= 8'h40
    ##2 bus_req.rd && bus_req.addr == 4'h4 |=> rdata == 32'h1)
    else $error("read past end not flagged");
  AST_MAKER_STR: assert property (bus_req.rd && bus_req.addr == 4'h3 && c_sel == 3'h1
    && c_idx == 8'h00 |=> rdata == 32'h0512)
    else $error("maker string layout wrong");
  COV_PAST_END: cover property (rd_data && c_ofs >= 8'h40);
  COV_UNIT: cover property (rd_data && c_sel == 3'h2);
  COV_STRING: cover property (bus_req.rd && bus_req.addr == 4'h3 && c_sel == 3'h1);
endmodule
bind ufs_device_descriptor_store descriptor_store_props u_props (
  .core_clk (core_clk),
  .rst_n    (rst_n),
  .bus_req  (bus_req),
  .rdata    (rdata)
);
`default_nettype wire

// file: tb/query_host.sv
// Host model issuing register accesses to the descriptor store
`timescale 1ns/1ps
`default_nettype none
module query_host (
  input wire logic                      core_clk,
  output var descriptor_store_pkg::bus_req_t bus_req,
  input wire logic [31:0]               rdata
);
  initial bus_req = '0;
  // Released address and data are inverted so stale values never pass
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req <= '{addr: ~a, wdata: 32'hFFFF_FFFF, wr: 1'b0, rd: 1'b0};
    #1 d = rdata;
  endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the descriptor store
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [15:0] MAKER = 16'h005A; // Arbitrary value
  localparam logic [31:0] PRE   = 32'h1234_5678;
  localparam logic [15:0] MDATE = 16'h0A1B;
  logic                           core_clk = 1'b0;
  logic                           rst_n = 1'b0;
  descriptor_store_pkg::bus_req_t bus_req;
  logic [31:0]                    rdata;
  logic [31:0]                    d;
  logic [7:0]                     dev [64];
  logic [7:0]                     slen [5];
  int                             errors = 0;
  int                             cmp_count = 0;
  int                             cycles = 0;
  always #50 core_clk = ~core_clk;
  ufs_device_descriptor_store #(.MAKER_IDENTITY_CODE(MAKER), .PRELOAD_MAX_SIZE(PRE),
    .MFG_DATE(MDATE)) uut (.core_clk(core_clk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata));
  query_host h (.core_clk(core_clk), .bus_req(bus_req), .rdata(rdata));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report;
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      final_report();
    end
  end
  initial begin
    foreach (dev[i]) dev[i] = 8'h00;
    dev[6'h00] = 8'h40; dev[6'h06] = 8'h01; dev[6'h07] = 8'h04; dev[6'h0A] = 8'h01;
    dev[6'h0B] = 8'h7F; dev[6'h0C] = 8'h03; dev[6'h0D] = 8'h01; dev[6'h0E] = 8'h0F;
    dev[6'h0F] = 8'h0F; dev[6'h10] = 8'h02; dev[6'h11] = 8'h10; dev[6'h15] = 8'h01;
    dev[6'h16] = 8'h03; dev[6'h17] = 8'h04; dev[6'h1A] = 8'h10; dev[6'h1B] = 8'h10;
    dev[6'h1C] = 8'h02; dev[6'h1F] = 8'h01; dev[6'h20] = 8'h07; dev[6'h21] = 8'h20;
    dev[6'h24] = 8'h20; dev[6'h2B] = 8'h11; dev[6'h2C] = 8'h02;
    {dev[6'h12], dev[6'h13]} = MDATE;
    {dev[6'h18], dev[6'h19]} = MAKER;
    {dev[6'h27], dev[6'h28], dev[6'h29], dev[6'h2A]} = PRE;
    slen = '{8'h12, 8'h22, 8'h04, 8'h0C, 8'h32};
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    h.wr(4'h0, 32'h0);
    h.rd(4'h3, d); chk("dev_len", 32'h40, d);
    for (int i = 0; i < 64; i++) begin
      h.rd(4'h2, d); chk("dev_byte", {24'h0, dev[i]}, d);
    end
    h.rd(4'h2, d); chk("past_end", 32'h0, d);
    h.rd(4'h4, d); chk("overrun", 32'h1, d);
    h.wr(4'h1, 32'h27);
    h.rd(4'h4, d); chk("overrun_clr", 32'h0, d);
    for (int i = 0; i < 5; i++) begin
      h.rd(4'h2, d); chk("preload", {24'h0, dev[6'h27 + i]}, d);
    end
    // Every string index, including the revision string at index two
    for (int i = 0; i < 5; i++) begin
      h.wr(4'h0, {16'h0, i[7:0], 8'h01});
      h.rd(4'h3, d); chk("str_len", {16'h0, 8'h05, slen[i]}, d);
    end
    h.wr(4'h0, 32'h0502);
    h.rd(4'h3, d); chk("unit_len", 32'h23, d);
    h.rd(4'h2, d); chk("unit_size", 32'h23, d);
    h.rd(4'h2, d); chk("unit_type", 32'h02, d);
    h.rd(4'h2, d); chk("unit_idx", 32'h05, d);
    // Read-only and unmapped places must not disturb the selection
    h.wr(4'h3, 32'hFF);
    h.wr(4'h9, 32'h0);
    h.rd(4'h3, d); chk("ro_len", 32'h23, d);
    h.rd(4'h9, d); chk("unmapped", 32'h0, d);
    final_report();
  end
endmodule
`default_nettype wire
